// file: rtl/eirq_pkg.sv
package eirq_pkg;
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_PEND   = 12'h004;
	localparam logic [11:0] ADDR_VECTOR = 12'h008;
	localparam int          CTRL_LE     = 0;
	localparam int          CTRL_MOD    = 1;
	localparam int          CTRL_PE     = 4;
	localparam int          CTRL_EDG    = 5;
	localparam int          CTRL_PDD    = 6;
	localparam int          CTRL_ACK    = 2;
	localparam int          STAT_FLAG   = 3;
	localparam int          STAT_LEVEL  = 7;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [4:0]  VEC_RESET   = 5'h00;
	localparam logic [4:0]  VEC_SWI     = 5'h01;
	localparam logic [4:0]  VEC_LVD     = 5'h02;
	localparam logic [4:0]  VEC_PIN     = 5'h03;
	localparam int          VEC_HW_TOP  = 23;
	localparam logic [15:0] VEC_TABLE_TOP = 16'hfffe;
	typedef struct packed {
		logic pull_device_disable;
		logic pin_polarity_select;
		logic pin_request_function_enable;
		logic edge_level_mode_select;
		logic pin_request_local_enable;
	} eirq_ctrl_s;
	typedef struct packed {
		logic        valid;
		logic [4:0]  number;
		logic [15:0] addr_high;
		logic [15:0] addr_low;
	} eirq_vec_s;
	typedef enum logic [1:0] {
		RS_IDLE = 2'b00,
		RS_WRSP = 2'b01,
		RS_RRSP = 2'b10
	} eirq_bus_e;
endpackage

// file: rtl/eirq_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module eirq_ctrl
	import eirq_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write channels
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read channels
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// request pin and its pull devices
	input  wire logic        irq_pin_in,
	output logic             pull_up_en,
	output logic             pull_down_en,
	output logic             pin_level,
	// stop-mode wake
	input  wire logic        stop_mode,
	output logic             stop_wake,
	// other sources and the cpu side
	input  wire logic [31:0] src_req,
	input  wire logic        global_mask,
	output logic             cpu_irq,
	output eirq_vec_s        vec_out
);
	// ------------------------------------------------------------
	// pin synchroniser and detection
	// ------------------------------------------------------------
	// prev_q is a third stage kept only for the edge compare
	logic       sync1_q, sync2_q, prev_q, flag_q, flag_d;
	logic       ack_pulse;
	eirq_ctrl_s ctrl_q, ctrl_d;
	logic       asserted, prev_asserted, edge_hit;

	// pin level reaches logic only through two flops, except the unclocked stop_wake path
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			// all stages equal after reset, so no false edge follows it
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			prev_q  <= 1'b1;
		end
		else
		begin
			sync1_q <= irq_pin_in;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// polarity maps the raw level onto asserted
	always_comb
	begin
		asserted      = ctrl_q.pin_polarity_select ? sync2_q : ~sync2_q;
		prev_asserted = ctrl_q.pin_polarity_select ? prev_q : ~prev_q;
		edge_hit      = ctrl_q.pin_request_function_enable & asserted & ~prev_asserted;
	end

	// flag: set beats clear, level mode blocks the clear while the pin is asserted
	always_comb
	begin
		flag_d = flag_q;
		if (ack_pulse && !(ctrl_q.edge_level_mode_select && asserted && ctrl_q.pin_request_function_enable))
			flag_d = 1'b0;
		if (edge_hit)
			flag_d = 1'b1;
		if (ctrl_q.pin_request_function_enable && ctrl_q.edge_level_mode_select && asserted)
			flag_d = 1'b1;
		if (!ctrl_q.pin_request_function_enable)
			flag_d = flag_q & ~ack_pulse;
	end

	// a single flag bit means repeats cannot queue
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end

	// pull device opposite to asserted polarity
	always_comb
	begin
		pull_up_en   = ctrl_q.pin_request_function_enable & ~ctrl_q.pull_device_disable
			& ~ctrl_q.pin_polarity_select;
		pull_down_en = ctrl_q.pin_request_function_enable & ~ctrl_q.pull_device_disable
			& ctrl_q.pin_polarity_select;
		// level reads zero when the pin is not the request input
		pin_level    = ctrl_q.pin_request_function_enable & sync2_q;
	end

	// unclocked wake: clocks may be halted in stop, so no flop here
	assign stop_wake = stop_mode & ctrl_q.pin_request_function_enable
		& (ctrl_q.pin_polarity_select ? irq_pin_in : ~irq_pin_in);

	// ------------------------------------------------------------
	// priority vector selection
	// ------------------------------------------------------------
	logic [31:0] pend;
	eirq_vec_s   vec_d, vec_q;

	// lowest number wins
	function automatic logic [4:0] first_set(input logic [31:0] v);
		logic [4:0] n;
		n = 5'h1f;
		for (int i = 31; i >= 0; i--)
			if (v[i])
				n = i[4:0];
		return n;
	endfunction

	// gather pending sources and pick the winner
	always_comb
	begin
		// upper vectors are user space; the pin slot comes from the flag
		pend = src_req;
		pend[31:VEC_HW_TOP+1] = '0;
		pend[VEC_PIN] = flag_q & ctrl_q.pin_request_local_enable;
		vec_d.valid   = (pend[0] | ~global_mask) & (|pend);
		vec_d.number  = first_set(pend);
		vec_d.addr_high = VEC_TABLE_TOP - {10'h000, vec_d.number, 1'b0};
		vec_d.addr_low  = vec_d.addr_high + 16'h0001;
	end

	// registered so the cpu sees a settled vector
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			vec_q <= '0;
		else
			vec_q <= vec_d;
	end
	// cpu request follows the registered vector
	assign vec_out = vec_q;
	assign cpu_irq = vec_q.valid;

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	eirq_bus_e   st_q, st_d;
	logic        aw_q, aw_d, w_q, w_d;
	logic [11:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [1:0]  resp_q, resp_d;
	logic        ack_d, ack_q;
	logic        ws_q, ws_d;

	// one decode for both directions so reads and writes refuse the same offsets
	function automatic logic is_mapped(input logic [11:0] a);
		return (a == ADDR_CTRL) || (a == ADDR_PEND) || (a == ADDR_VECTOR);
	endfunction

	// handshake outputs straight from state, except arready, which also takes awvalid

	assign s_axi_awready = (st_q == RS_IDLE) & ~aw_q;
	assign s_axi_wready  = (st_q == RS_IDLE) & ~w_q;
	assign s_axi_arready = (st_q == RS_IDLE) & ~aw_q & ~w_q & ~s_axi_awvalid;
	assign s_axi_bvalid  = (st_q == RS_WRSP);
	assign s_axi_rvalid  = (st_q == RS_RRSP);
	assign s_axi_bresp   = resp_q;
	assign s_axi_rresp   = resp_q;
	assign s_axi_rdata   = rd_q;
	assign ack_pulse     = ack_q;

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	// address and data taken in either order; writes win over reads
	always_comb
	begin
		st_d   = st_q;
		aw_d   = aw_q;
		w_d    = w_q;
		awa_d  = awa_q;
		wd_d   = wd_q;
		ws_d   = ws_q;
		rd_d   = rd_q;
		resp_d = resp_q;
		ctrl_d = ctrl_q;
		ack_d  = 1'b0;
		case (st_q)
			RS_IDLE:
			begin
				// either half may come first; each is held until both are in
				if (s_axi_awvalid && s_axi_awready)
				begin
					aw_d  = 1'b1;
					awa_d = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready)
				begin
					w_d  = 1'b1;
					wd_d = s_axi_wdata;
					ws_d = s_axi_wstrb[0];
				end
				// commit one cycle after both halves are held
				if (aw_q && w_q)
				begin
					aw_d   = 1'b0;
					w_d    = 1'b0;
					st_d   = RS_WRSP;
					resp_d = 2'b00;
					// every control bit sits in byte lane 0, so its strobe gates the write
					if (awa_q == ADDR_CTRL && ws_q)
					begin
						if (wd_q[CTRL_ACK])
							ack_d = 1'b1;
						ctrl_d.pull_device_disable         = wd_q[CTRL_PDD];
						ctrl_d.pin_polarity_select         = wd_q[CTRL_EDG];
						ctrl_d.pin_request_function_enable = wd_q[CTRL_PE];
						ctrl_d.edge_level_mode_select      = wd_q[CTRL_MOD];
						ctrl_d.pin_request_local_enable    = wd_q[CTRL_LE];
					end
					else if (!is_mapped(awa_q))
						resp_d = 2'b10;
				end
				// read data is registered, so rvalid follows ar by one cycle
				else if (s_axi_arvalid && s_axi_arready)
				begin
					st_d   = RS_RRSP;
					resp_d = is_mapped(s_axi_araddr) ? 2'b00 : 2'b10;
					rd_d   = '0;
					case (s_axi_araddr)
						ADDR_CTRL:
						begin
							rd_d[CTRL_PDD]   = ctrl_q.pull_device_disable;
							rd_d[CTRL_EDG]   = ctrl_q.pin_polarity_select;
							rd_d[CTRL_PE]    = ctrl_q.pin_request_function_enable;
							rd_d[CTRL_MOD]   = ctrl_q.edge_level_mode_select;
							rd_d[CTRL_LE]    = ctrl_q.pin_request_local_enable;
							rd_d[STAT_FLAG]  = flag_q;
							rd_d[STAT_LEVEL] = pin_level;
						end
						ADDR_PEND:   rd_d = pend;
						ADDR_VECTOR: rd_d = {vec_q.valid, 10'h000, vec_q.number, vec_q.addr_high};
						default:     rd_d = '0;
					endcase
				end
			end
			// responses stand until the master takes them
			RS_WRSP:
			begin
				if (s_axi_bready)
					st_d = RS_IDLE;
			end
			RS_RRSP:
			begin
				if (s_axi_rready)
					st_d = RS_IDLE;
			end
			default: st_d = RS_IDLE;
		endcase
	end

	// one register stage for the whole slave; reset returns it to idle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q   <= RS_IDLE;
			aw_q   <= 1'b0;
			w_q    <= 1'b0;
			awa_q  <= '0;
			wd_q   <= '0;
			ws_q   <= 1'b0;
			rd_q   <= '0;
			resp_q <= 2'b00;
			ctrl_q <= eirq_ctrl_s'(CTRL_RESET[4:0]);
			ack_q  <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			aw_q   <= aw_d;
			w_q    <= w_d;
			awa_q  <= awa_d;
			wd_q   <= wd_d;
			ws_q   <= ws_d;
			rd_q   <= rd_d;
			resp_q <= resp_d;
			ctrl_q <= ctrl_d;
			ack_q  <= ack_d;
		end
	end
endmodule
`default_nettype wire

// file: dv/eirq_src.sv
`timescale 1ns/10ps
`default_nettype none
module eirq_src
(
	input  wire logic aclk,
	input  wire logic drv_en,
	input  wire logic drv_val,
	input  wire logic pull_up_en,
	input  wire logic pull_down_en,
	output logic      irq_pin_in
);
	logic wander_q = 1'b0;
	// a floating pin keeps moving so no stale level passes for a real one
	always_ff @(posedge aclk)
		wander_q <= !wander_q;
	// driver wins, else the pull, else the floating value
	assign irq_pin_in = drv_en ? drv_val : pull_up_en | (!pull_down_en & wander_q);
endmodule
`default_nettype wire

// file: dv/eirq_properties.sv
`timescale 1ns/10ps
`default_nettype none
module eirq_properties
	import eirq_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        pull_up_en,
	input wire logic        pull_down_en,
	input wire logic        stop_mode,
	input wire logic        stop_wake,
	input wire logic [31:0] src_req,
	input wire logic        global_mask,
	input wire logic        cpu_irq,
	input wire eirq_vec_s   vec_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// pulls, wake and vector layout
	a_pull_one_way: assert property (!(pull_up_en && pull_down_en)) else $error("pulls clash");
	a_wake_in_stop: assert property (stop_wake |-> stop_mode) else $error("wake out of stop");
	a_vec_high: assert property (vec_out.valid |->
		vec_out.addr_high == 16'hfffe - {10'h0, vec_out.number, 1'b0}) else $error("vector address");
	a_vec_low: assert property (vec_out.valid |->
		vec_out.addr_low == vec_out.addr_high + 16'h1) else $error("vector low byte");
	a_no_user_vec: assert property (vec_out.valid |-> vec_out.number <= 5'h17) else $error("user vector");
	// priority and masking, four cycles of settle
	a_reset_wins: assert property (src_req[0] [*4] |->
		cpu_irq && vec_out.number == 5'h00) else $error("reset vector lost");
	a_mask_holds: assert property ((global_mask && !src_req[0]) [*4] |-> !cpu_irq) else $error("mask ignored");
	a_req_forward: assert property ((!global_mask && src_req[2]) [*4] |->
		cpu_irq && vec_out.number <= 5'h02) else $error("request lost");
endmodule
bind eirq_ctrl eirq_properties eirq_properties_i (.*);
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("unexpected %0t %h %h", $time, g, e); end end
module testbench
	import eirq_pkg::*;
;
	logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stop_mode = 1'b0, global_mask = 1'b1;
	logic        drv_en = 1'b0, drv_val = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, irq_pin_in, pull_up_en, pull_down_en, pin_level, stop_wake, cpu_irq;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, src_req = 32'h0, lfsr = 32'hfeb0, v;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [33:0] exp_q[$], exp_e;
	logic [4:0]  want;
	eirq_vec_s   vec_out;
	int          failures = 0, total_checks = 0, cycles = 0;
	eirq_ctrl eirq_ctrl_i (.*);
	eirq_src eirq_src_i (.*);
	always #20 aclk = !aclk;
	task automatic end_of_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// random stimulus source
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// each channel holds until its own ready; every answer leaves a note
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
		exp_q.push_back(e);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) s_axi_bready <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) s_axi_rready <= 1'b0;
			#1;
		end while ({s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} != 5'h00);
	endtask
	// error answers carry no data worth comparing
	always @(posedge aclk)
	begin
		cycles++;
		if (s_axi_rvalid && s_axi_rready)
		begin
			exp_e = exp_q.pop_front();
			`CHK({s_axi_rresp, exp_e[33] ? exp_e[31:0] : s_axi_rdata}, exp_e)
		end
		if (s_axi_bvalid && s_axi_bready)
		begin
			exp_e = exp_q.pop_front();
			`CHK({s_axi_bresp, 32'h0}, exp_e)
		end
		if (cycles == 4000)
		begin
			failures++;
			end_of_test;
		end
	end
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		bus(0, 12'h000, 32'h0, 34'h0);
		bus(0, 12'h00c, 32'h0, 34'h200000000);
		bus(1, 12'h00c, 32'h0, 34'h200000000);
		bus(1, 12'h004, 32'hff, 34'h0);
		bus(0, 12'h000, 32'h0, 34'h0);
		for (int i = 0; i < 4; i++)
		begin
			bus(1, 12'h000, {25'h0, i[1:0], 5'h10}, 34'h0);
			`CHK({pull_up_en, pull_down_en}, {i == 0, i == 1})
		end
		drv_en <= 1'b1;
		bus(1, 12'h000, 32'h35, 34'h0);
		global_mask <= 1'b0;
		drv_val <= 1'b1;
		repeat (8) @(posedge aclk);
		bus(0, 12'h000, 32'h0, 34'hb9);
		`CHK({cpu_irq, vec_out.number, vec_out.addr_high}, {1'b1, VEC_PIN, 16'hfff8})
		bus(1, 12'h000, 32'h35, 34'h0);
		bus(0, 12'h000, 32'h0, 34'hb1);
		bus(1, 12'h000, 32'h30, 34'h0);
		drv_val <= 1'b0;
		repeat (4) @(posedge aclk);
		drv_val <= 1'b1;
		repeat (8) @(posedge aclk);
		bus(0, 12'h000, 32'h0, 34'hb8);
		`CHK(cpu_irq, 1'b0)
		bus(1, 12'h000, 32'h36, 34'h0);
		bus(0, 12'h000, 32'h0, 34'hba);
		drv_val <= 1'b0;
		repeat (4) @(posedge aclk);
		bus(1, 12'h000, 32'h36, 34'h0);
		bus(0, 12'h000, 32'h0, 34'h32);
		stop_mode <= 1'b1;
		drv_val <= 1'b1;
		@(posedge aclk);
		`CHK(stop_wake, 1'b1)
		stop_mode <= 1'b0;
		bus(1, 12'h000, 32'h04, 34'h0);
		// three fixed patterns, then random ones; upper vectors must be ignored
		for (int k = 0; k < 11; k++)
		begin
			lfsr = lfsr_next(lfsr);
			v = k < 3 ? 32'h8 - (32'h4 >> k) : (lfsr & 32'hff00fff0) | 32'h00800000;
			src_req <= v;
			want = 5'h17;
			for (int b = 23; b >= 0; b--)
				if (b != 3 && v[b]) want = b[4:0];
			repeat (4) @(posedge aclk);
			#1;
			`CHK({cpu_irq, vec_out.number}, {1'b1, want})
			bus(0, 12'h004, 32'h0, {2'b00, v & 32'h00fffff7});
			bus(0, 12'h008, 32'h0, {2'b00, 1'b1, 10'h000, want, 16'hfffe - {10'h000, want, 1'b0}});
		end
		global_mask <= 1'b1;
		src_req <= 32'h6;
		repeat (4) @(posedge aclk);
		#1;
		`CHK(cpu_irq, 1'b0)
		end_of_test;
	end
endmodule
`default_nettype wire
